// ---- shared/irq_nest_pkg.sv ----
// Constants and types for the nested interrupt priority block
package irq_nest_pkg;
  localparam int NUM_VEC = 14;
  localparam int NUM_PRIO_REGS = 4;
  localparam int NUM_EXT = 4;
  // APB byte addresses
  localparam logic [7:0] ADDR_PRIO_0 = 8'h00;
  localparam logic [7:0] ADDR_PRIO_1 = 8'h04;
  localparam logic [7:0] ADDR_PRIO_2 = 8'h08;
  localparam logic [7:0] ADDR_PRIO_3 = 8'h0C;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [3:0] PRIO3_HIGH_ONES = 4'hF;
  // Level encodings
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  // Sense select encodings
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  // External control field positions
  localparam int EC_SEL1_HI = 7;
  localparam int EC_SEL1_LO = 6;
  localparam int EC_POL_B = 5;
  localparam int EC_SEL2_HI = 4;
  localparam int EC_SEL2_LO = 3;
  localparam int EC_POL_A = 2;
  localparam int EC_TLI_RISE = 1;
  localparam int EC_TLI_EN = 0;
  // Vector numbers
  localparam logic [3:0] VEC_TLI = 4'h0;
  localparam logic [3:0] VEC_EXT0 = 4'h2;
  localparam logic [3:0] VEC_UNUSED = 4'h6;
  localparam logic [3:0] VEC_NONE = 4'hF;
  // Halt exit capable maskable vectors (1,2,3,4,5 always; 7,13 conditional)
  localparam logic [13:0] HALT_EXIT_FIXED = 14'h003F;
  localparam int VEC_SPI = 7;
  localparam int VEC_PWM = 13;
  // Cpu operations
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_UNMASK = 4'h1, OP_HALT = 4'h2, OP_WFI = 4'h3,
    OP_MASK = 4'h4, OP_TRAP = 4'h5, OP_RETURN_FROM_IRQ_OP = 4'h6, OP_RESTORE = 4'h7
  } cpu_op_t;
endpackage : irq_nest_pkg

// ---- hdl/nested_irq_priority_and_ext_sense.sv ----
// Nested interrupt priority logic with external line sensitivity
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module nested_irq_priority_and_ext_sense #(
  parameter int LINE_WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] periphIrq,
  input wire logic spiSlaveMode,
  input wire logic pwmExtClock,
  input wire logic tliPin,
  input wire logic [LINE_WIDTH-1:0] extLineZero,
  input wire logic [LINE_WIDTH-1:0] extLineOne,
  input wire logic [LINE_WIDTH-1:0] extLineTwo,
  input wire logic [LINE_WIDTH-1:0] extLineThree,
  input wire logic [3:0] cpuOp,
  input wire logic [1:0] restoreLevel,
  input wire logic cpuReady,
  input wire logic haltMode,
  output logic irqRequest,
  output logic [3:0] irqVector,
  output logic trapTake,
  output logic irqTake,
  output logic [1:0] currentLevel,
  output logic jumpIfMasked,
  output logic jumpIfUnmasked,
  output logic haltExit
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0] prio;
    logic [7:0] extCtrl;
    logic [1:0] level;
    logic [3:0] extPend;
    logic tliPend;
    logic [3:0] lineZeroLast;
    logic [3:0] lineOneLast;
    logic [3:0] lineTwoLast;
    logic [3:0] lineThreeLast;
    logic tliLast;
    logic [3:0] activeVec;
    logic [1:0] activePrio;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ****************************************
  // Line sensing
  // ****************************************
  logic [3:0] lineNow;
  logic [3:0] lineLevelHit;
  logic [3:0] lineEdgeHit;
  logic [3:0][1:0] lineSel;
  logic [3:0] lineInv;
  logic [3:0][3:0] lineLast;

  assign lineNow[0] = |extLineZero;
  assign lineNow[1] = |extLineOne;
  assign lineNow[2] = |extLineTwo;
  assign lineNow[3] = |extLineThree;
  assign lineLast[0] = cur.lineZeroLast;
  assign lineLast[1] = cur.lineOneLast;
  assign lineLast[2] = cur.lineTwoLast;
  assign lineLast[3] = cur.lineThreeLast;
  // Lines 0,1 share one select, 2,3 the other
  assign lineSel[0] = cur.extCtrl[irq_nest_pkg::EC_SEL2_HI -: 2];
  assign lineSel[1] = cur.extCtrl[irq_nest_pkg::EC_SEL2_HI -: 2];
  assign lineSel[2] = cur.extCtrl[irq_nest_pkg::EC_SEL1_HI -: 2];
  assign lineSel[3] = cur.extCtrl[irq_nest_pkg::EC_SEL1_HI -: 2];
  assign lineInv[0] = cur.extCtrl[irq_nest_pkg::EC_POL_A];
  assign lineInv[1] = 1'b0;
  assign lineInv[2] = cur.extCtrl[irq_nest_pkg::EC_POL_B];
  assign lineInv[3] = 1'b0;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sense
      logic orLast;
      logic rise;
      logic fall;
      logic lvl;
      assign orLast = |lineLast[g];
      assign rise = lineNow[g] & ~orLast;
      assign fall = ~lineNow[g] & orLast;
      // Polarity only exists on lines 0 and 2
      assign lvl = lineInv[g] ? lineNow[g] : ~lineNow[g];
      always_comb begin
        lineEdgeHit[g] = 1'b0;
        lineLevelHit[g] = 1'b0;
        case (lineSel[g])
          irq_nest_pkg::SENSE_FALL_LOW: begin
            lineEdgeHit[g] = lineInv[g] ? rise : fall;
            lineLevelHit[g] = lvl;
          end
          irq_nest_pkg::SENSE_RISE: lineEdgeHit[g] = lineInv[g] ? fall : rise;
          irq_nest_pkg::SENSE_FALL: lineEdgeHit[g] = lineInv[g] ? rise : fall;
          default: lineEdgeHit[g] = rise | fall;
        endcase
      end
    end
  endgenerate

  // ****************************************
  // Arbitration
  // ****************************************
  logic [13:0] pending;
  logic [13:0] haltCap;
  logic [3:0] winVec;
  logic [1:0] winPrio;
  logic winFound;
  logic tliFire;

  function automatic logic [1:0] rank(input logic [1:0] lv);
    case (lv)
      irq_nest_pkg::LVL0: rank = 2'h0;
      irq_nest_pkg::LVL1: rank = 2'h1;
      irq_nest_pkg::LVL2: rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction : rank

  always_comb begin
    pending = periphIrq;
    pending[irq_nest_pkg::VEC_TLI] = 1'b0;
    pending[irq_nest_pkg::VEC_UNUSED] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pending[int'(irq_nest_pkg::VEC_EXT0) + i] = cur.extPend[i] | lineLevelHit[i];
    end
    haltCap = irq_nest_pkg::HALT_EXIT_FIXED;
    haltCap[irq_nest_pkg::VEC_SPI] = spiSlaveMode;
    haltCap[irq_nest_pkg::VEC_PWM] = pwmExtClock;
    haltCap[irq_nest_pkg::VEC_TLI] = 1'b0;
  end

  always_comb begin
    logic [1:0] fieldLv;
    logic [13:0] elig;
    fieldLv = 2'h0;
    winVec = irq_nest_pkg::VEC_NONE;
    winPrio = irq_nest_pkg::LVL3;
    winFound = 1'b0;
    elig = haltMode ? (pending & haltCap) : pending;
    // Lowest index wins ties; strict greater keeps the earlier one
    for (int v = 1; v < 14; v++) begin
      fieldLv = cur.prio[v / 4][2 * (v % 4) +: 2];
      if (elig[v] && rank(fieldLv) > rank(cur.level) &&
          (!winFound || rank(fieldLv) > rank(winPrio))) begin
        winVec = 4'(v);
        winPrio = fieldLv;
        winFound = 1'b1;
      end
    end
  end

  assign tliFire = cur.tliPend;
  assign irqRequest = tliFire | winFound;
  assign irqVector = tliFire ? irq_nest_pkg::VEC_TLI : winVec;
  assign irqTake = cpuReady & irqRequest;
  assign trapTake = cpuReady & (cpuOp == 4'(irq_nest_pkg::OP_TRAP));
  assign currentLevel = cur.level;
  assign jumpIfMasked = cur.level == irq_nest_pkg::LVL3;
  assign jumpIfUnmasked = cur.level != irq_nest_pkg::LVL3;
  assign haltExit = haltMode & (tliFire | winFound);
  assign prdata = cur.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] wb;
    logic [7:0] masked;
    logic [3:0] clrPend;
    next_cur = cur;
    wr = psel & penable & pwrite;
    // Read data captured in setup so it stands through the access edge
    rd = psel & ~penable & ~pwrite;
    wb = pwdata[7:0];
    masked = 8'h00;
    clrPend = 4'h0;
    for (int i = 0; i < 4; i++) begin
      next_cur.extPend[i] = cur.extPend[i] | lineEdgeHit[i];
    end
    next_cur.lineZeroLast = extLineZero;
    next_cur.lineOneLast = extLineOne;
    next_cur.lineTwoLast = extLineTwo;
    next_cur.lineThreeLast = extLineThree;
    next_cur.tliLast = tliPin;
    if (wr) begin
      for (int r = 0; r < 4; r++) begin
        if (paddr == 8'(4 * r)) begin
          for (int f = 0; f < 4; f++) begin
            if (wb[2 * f +: 2] != irq_nest_pkg::LVL0) begin
              next_cur.prio[r][2 * f +: 2] = wb[2 * f +: 2];
            end
          end
        end
      end
      next_cur.prio[3][7:4] = irq_nest_pkg::PRIO3_HIGH_ONES;
      if (paddr == irq_nest_pkg::ADDR_EXT_CTRL) begin
        masked = cur.extCtrl;
        if (cur.level == irq_nest_pkg::LVL3) begin
          masked[7:2] = wb[7:2];
        end
        // Edge select bit only moves while the pin is disabled
        if (!cur.extCtrl[irq_nest_pkg::EC_TLI_EN]) begin
          masked[irq_nest_pkg::EC_TLI_RISE] = wb[irq_nest_pkg::EC_TLI_RISE];
        end
        masked[irq_nest_pkg::EC_TLI_EN] = wb[irq_nest_pkg::EC_TLI_EN];
        if (masked[7:2] != cur.extCtrl[7:2]) begin
          clrPend = 4'hF;
        end
        next_cur.extCtrl = masked;
      end
    end
    // Clearing loses to a same-cycle edge
    for (int i = 0; i < 4; i++) begin
      if (clrPend[i] && !lineEdgeHit[i]) begin
        next_cur.extPend[i] = 1'b0;
      end
    end
    // Cpu operations
    case (cpuOp)
      4'(irq_nest_pkg::OP_UNMASK), 4'(irq_nest_pkg::OP_HALT),
      4'(irq_nest_pkg::OP_WFI): next_cur.level = irq_nest_pkg::LVL0;
      4'(irq_nest_pkg::OP_MASK): next_cur.level = irq_nest_pkg::LVL3;
      4'(irq_nest_pkg::OP_TRAP): if (cpuReady) begin
        next_cur.level = irq_nest_pkg::LVL3;
      end
      4'(irq_nest_pkg::OP_RETURN_FROM_IRQ_OP), 4'(irq_nest_pkg::OP_RESTORE): begin
        next_cur.level = restoreLevel;
      end
      default: next_cur.level = next_cur.level;
    endcase
    if (irqTake) begin
      if (tliFire) begin
        next_cur.level = irq_nest_pkg::LVL3;
        next_cur.tliPend = 1'b0;
      end else begin
        // Same vector re-enters when its raised priority beats current
        next_cur.level = winPrio;
        next_cur.activeVec = winVec;
        next_cur.activePrio = winPrio;
        for (int i = 0; i < 4; i++) begin
          if (winVec == 4'(int'(irq_nest_pkg::VEC_EXT0) + i) && !lineEdgeHit[i]) begin
            next_cur.extPend[i] = 1'b0;
          end
        end
      end
    end
    // New pin edge beats the entry clear
    if (cur.extCtrl[irq_nest_pkg::EC_TLI_EN] &&
        (cur.extCtrl[irq_nest_pkg::EC_TLI_RISE] ? (tliPin & ~cur.tliLast)
                                                : (~tliPin & cur.tliLast))) begin
      next_cur.tliPend = 1'b1;
    end
    if (rd) begin
      next_cur.rdata = 32'h0000_0000;
      case (paddr)
        irq_nest_pkg::ADDR_PRIO_0: next_cur.rdata[7:0] = cur.prio[0];
        irq_nest_pkg::ADDR_PRIO_1: next_cur.rdata[7:0] = cur.prio[1];
        irq_nest_pkg::ADDR_PRIO_2: next_cur.rdata[7:0] = cur.prio[2];
        irq_nest_pkg::ADDR_PRIO_3: next_cur.rdata[7:0] = cur.prio[3];
        irq_nest_pkg::ADDR_EXT_CTRL: next_cur.rdata[7:0] = cur.extCtrl;
        irq_nest_pkg::ADDR_STATUS: next_cur.rdata[11:0] =
          {cur.extPend, cur.tliPend, cur.activeVec[2:0], cur.level, 2'h0};
        default: next_cur.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= '0;
      cur.prio <= {4{irq_nest_pkg::PRIO_RESET}};
      cur.extCtrl <= irq_nest_pkg::EXT_CTRL_RESET;
      cur.level <= irq_nest_pkg::LVL3;
      cur.activeVec <= irq_nest_pkg::VEC_NONE;
      cur.activePrio <= irq_nest_pkg::LVL3;
      cur.lineZeroLast <= 4'hF;
      cur.lineOneLast <= 4'hF;
      cur.lineTwoLast <= 4'hF;
      cur.lineThreeLast <= 4'hF;
      cur.tliLast <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : nested_irq_priority_and_ext_sense

// ---- bench/nested_irq_props.sv ----
// Concurrent checks on the nested interrupt priority block
`timescale 1ns/1ps
module nested_irq_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] cpuOp,
  input wire logic [1:0] restoreLevel,
  input wire logic cpuReady,
  input wire logic irqRequest,
  input wire logic [3:0] irqVector,
  input wire logic trapTake,
  input wire logic irqTake,
  input wire logic [1:0] currentLevel,
  input wire logic jumpIfMasked,
  input wire logic jumpIfUnmasked
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************
  // Checks
  // ****************
  zero_wait_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("register access not answered at once");
  take_cause_a: assert property (irqTake |-> cpuReady && irqRequest &&
    (irqVector == 4'h0 || currentLevel != 2'h3))
    else $error("take without request");
  mask_op_a: assert property (cpuOp == irq_nest_pkg::OP_MASK && !irqTake |=> currentLevel == 2'h3)
    else $error("mask op did not load 11");
  unmask_op_a: assert property ((cpuOp inside {4'h1, 4'h2, 4'h3}) && !irqTake |=> currentLevel == 2'h2)
    else $error("unmask op did not load 10");
  restore_op_a: assert property ((cpuOp inside {4'h6, 4'h7}) && !irqTake |=> currentLevel == $past(restoreLevel))
    else $error("level not restored");
  trap_level_a: assert property (trapTake && !irqTake |=> currentLevel == 2'h3)
    else $error("trap did not mask");
  level_hold_a: assert property (cpuOp == 4'h0 && !irqTake |=> $stable(currentLevel))
    else $error("level changed without cause");
  jump_flags_a: assert property (jumpIfMasked == (currentLevel == 2'h3) && jumpIfUnmasked != jumpIfMasked)
    else $error("jump conditions wrong");
  masked_pin_a: assert property (irqRequest && currentLevel == 2'h3 |-> irqVector == 4'h0)
    else $error("maskable request at level 3");
  pin_entry_a: assert property (irqTake && irqVector == 4'h0 |=> currentLevel == 2'h3)
    else $error("pin entry not at level 3");
  entry_level_a: assert property (irqTake && irqVector != 4'h0 |=> currentLevel != 2'h2)
    else $error("entry loaded level 0");
  vec_range_a: assert property (irqRequest |-> irqVector != 4'h6 && irqVector <= 4'hD)
    else $error("bad vector number");
endmodule : nested_irq_props

bind nested_irq_priority_and_ext_sense nested_irq_props props_u (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .cpuOp(cpuOp), .restoreLevel(restoreLevel), .cpuReady(cpuReady),
  .irqRequest(irqRequest), .irqVector(irqVector), .trapTake(trapTake), .irqTake(irqTake),
  .currentLevel(currentLevel), .jumpIfMasked(jumpIfMasked), .jumpIfUnmasked(jumpIfUnmasked));

// ---- bench/cpu_core_model.sv ----
// Core side model that takes interrupts and keeps the level stack
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] opCmd,
  input wire logic readyCmd,
  input wire logic irqTake,
  input wire logic trapTake,
  input wire logic [1:0] currentLevel,
  output logic [3:0] cpuOp,
  output logic [1:0] restoreLevel,
  output logic cpuReady
);
  logic [1:0] stack [16];
  int depth = 0;
  assign cpuOp = opCmd;
  assign cpuReady = readyCmd;
  // Empty stack answers 11, the masked main program after reset
  assign restoreLevel = (depth > 0) ? stack[depth-1] : 2'h3;
  always @(posedge core_clk) begin
    if (rst) begin
      depth <= 0;
    end else if (irqTake || trapTake) begin
      stack[depth] <= currentLevel;
      depth <= depth + 1;
    end else if ((opCmd == irq_nest_pkg::OP_RETURN_FROM_IRQ_OP || opCmd == irq_nest_pkg::OP_RESTORE) && depth > 0) begin
      depth <= depth - 1;
    end
  end
endmodule : cpu_core_model

// ---- bench/nested_irq_priority_and_ext_sense_tb.sv ----
// Self-checking testbench for the nested interrupt priority block
`timescale 1ns/1ps
module nested_irq_priority_and_ext_sense_tb;
  logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irqRequest, trapTake, irqTake, jumpIfMasked, jumpIfUnmasked, haltExit;
  logic [13:0] periphIrq = 14'h0000;
  logic spiSlaveMode = 1'h0, pwmExtClock = 1'h0, tliPin = 1'h1, cpuReady, readyCmd = 1'h0;
  logic haltMode = 1'h0;
  logic [3:0] extZero = 4'hF, extIdle = 4'hF, cpuOp, opCmd = 4'h0, irqVector;
  logic [1:0] restoreLevel, currentLevel;
  int errors = 0, total_checks = 0;
  nested_irq_priority_and_ext_sense #(.LINE_WIDTH(4)) dut_u (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periphIrq(periphIrq), .spiSlaveMode(spiSlaveMode), .pwmExtClock(pwmExtClock),
    .tliPin(tliPin), .extLineZero(extZero), .extLineOne(extIdle), .extLineTwo(extIdle),
    .extLineThree(extIdle), .cpuOp(cpuOp), .restoreLevel(restoreLevel), .cpuReady(cpuReady),
    .haltMode(haltMode), .irqRequest(irqRequest), .irqVector(irqVector), .trapTake(trapTake),
    .irqTake(irqTake), .currentLevel(currentLevel), .jumpIfMasked(jumpIfMasked),
    .jumpIfUnmasked(jumpIfUnmasked), .haltExit(haltExit));
  cpu_core_model core_u (.core_clk(core_clk), .rst(rst), .opCmd(opCmd), .readyCmd(readyCmd),
    .irqTake(irqTake), .trapTake(trapTake), .currentLevel(currentLevel), .cpuOp(cpuOp),
    .restoreLevel(restoreLevel), .cpuReady(cpuReady));
  initial forever #12.5 core_clk = ~core_clk;
  // ****************
  // Helpers
  // ****************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    // Request held until pready is seen high; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0; penable <= 1'h0;
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(nm, q, e);
  endtask : rd
  task automatic lvl(input string nm, input logic [1:0] e);
    check(nm, {30'h0, currentLevel}, {30'h0, e});
  endtask : lvl
  task automatic op(input logic [3:0] o);
    @(posedge core_clk);
    opCmd <= o;
    readyCmd <= (o == irq_nest_pkg::OP_TRAP);
    @(posedge core_clk);
    opCmd <= 4'h0; readyCmd <= 1'h0;
    @(negedge core_clk);
  endtask : op
  task automatic take();
    @(posedge core_clk);
    readyCmd <= 1'h1;
    @(posedge core_clk);
    readyCmd <= 1'h0;
    @(negedge core_clk);
  endtask : take
  task automatic wait_req();
    int n;
    n = 0;
    while (irqRequest !== 1'h1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_req
  // ****************
  // Scenarios
  // ****************
  task automatic test_reset();
    for (int i = 0; i < 4; i++) rd("prio", 8'(4 * i), 32'hFF);
    rd("extctrl", irq_nest_pkg::ADDR_EXT_CTRL, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    lvl("resetlevel", 2'h3);
  endtask : test_reset
  task automatic test_ops();
    logic [3:0] unm [3];
    unm = '{irq_nest_pkg::OP_UNMASK, irq_nest_pkg::OP_HALT, irq_nest_pkg::OP_WFI};
    foreach (unm[i]) begin
      op(irq_nest_pkg::OP_MASK);
      lvl("mask", irq_nest_pkg::LVL3);
      check("jrm", {31'h0, jumpIfMasked}, 32'h1);
      op(unm[i]);
      lvl("unmask", irq_nest_pkg::LVL0);
      check("jump_if_unmasked_op", {31'h0, jumpIfUnmasked}, 32'h1);
    end
    op(irq_nest_pkg::OP_TRAP);
    repeat (3) @(negedge core_clk);
    lvl("trap", irq_nest_pkg::LVL3);
    op(irq_nest_pkg::OP_RESTORE);
    lvl("restore", irq_nest_pkg::LVL0);
  endtask : test_ops
  task automatic test_prio();
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_1, 32'hCF);
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_1, 32'h64);
    rd("keep10", irq_nest_pkg::ADDR_PRIO_1, 32'h44);
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_3, 32'h00);
    rd("prio3", irq_nest_pkg::ADDR_PRIO_3, 32'hF0);
  endtask : test_prio
  task automatic test_arb();
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_0, 32'hF7);
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_2, 32'hF0);
    @(posedge core_clk);
    periphIrq <= 14'h0302;
    @(negedge core_clk);
    check("softwin", {28'h0, irqVector}, 32'h8);
    take();
    lvl("entry", irq_nest_pkg::LVL2);
    @(posedge core_clk);
    periphIrq <= 14'h0002;
    @(negedge core_clk);
    check("below", {31'h0, irqRequest}, 32'h0);
    op(irq_nest_pkg::OP_RETURN_FROM_IRQ_OP);
    lvl("return_from_irq_op", irq_nest_pkg::LVL0);
    check("vec1", {28'h0, irqVector}, 32'h1);
    take();
    lvl("entry1", irq_nest_pkg::LVL1);
    @(posedge core_clk);
    periphIrq <= 14'h0000;
    op(irq_nest_pkg::OP_RETURN_FROM_IRQ_OP);
  endtask : test_arb
  task automatic test_halt();
    @(posedge core_clk);
    haltMode <= 1'h1;
    periphIrq <= 14'h0100;
    @(negedge core_clk);
    check("haltblock", {31'h0, irqRequest}, 32'h0);
    @(posedge core_clk);
    spiSlaveMode <= 1'h1;
    periphIrq <= 14'h0180;
    @(negedge core_clk);
    check("haltspi", {28'h0, irqVector}, 32'h7);
    check("haltexit", {31'h0, haltExit}, 32'h1);
    @(posedge core_clk);
    haltMode <= 1'h0; spiSlaveMode <= 1'h0; periphIrq <= 14'h0000;
  endtask : test_halt
  task automatic test_ext();
    op(irq_nest_pkg::OP_MASK);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h08);
    rd("rise", irq_nest_pkg::ADDR_EXT_CTRL, 32'h08);
    op(irq_nest_pkg::OP_UNMASK);
    @(posedge core_clk);
    extZero <= 4'h0;
    repeat (3) @(negedge core_clk);
    check("nofall", {31'h0, irqRequest}, 32'h0);
    @(posedge core_clk);
    extZero <= 4'h4;
    wait_req();
    check("orpins", {28'h0, irqVector}, 32'h2);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h18);
    rd("locked", irq_nest_pkg::ADDR_EXT_CTRL, 32'h08);
    apb(1'h0, irq_nest_pkg::ADDR_STATUS, 32'h0);
    check("pend", {28'h0, q[11:8]}, 32'h1);
    op(irq_nest_pkg::OP_MASK);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h10);
    apb(1'h0, irq_nest_pkg::ADDR_STATUS, 32'h0);
    check("cleared", {28'h0, q[11:8]}, 32'h0);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h04);
    op(irq_nest_pkg::OP_UNMASK);
    check("highlvl", {28'h0, irqVector}, 32'h2);
    op(irq_nest_pkg::OP_MASK);
  endtask : test_ext
  task automatic test_tli();
    apb(1'h1, irq_nest_pkg::ADDR_PRIO_0, 32'hF4);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h12);
    apb(1'h1, irq_nest_pkg::ADDR_EXT_CTRL, 32'h13);
    @(posedge core_clk);
    tliPin <= 1'h0;
    @(posedge core_clk);
    tliPin <= 1'h1;
    wait_req();
    check("pinlvl3", {28'h0, irqVector}, 32'h0);
    take();
    lvl("pinentry", irq_nest_pkg::LVL3);
    op(irq_nest_pkg::OP_RETURN_FROM_IRQ_OP);
  endtask : test_tli
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    test_reset();
    test_ops();
    test_prio();
    test_arb();
    test_halt();
    test_ext();
    test_tli();
    report_and_stop();
  end
endmodule : nested_irq_priority_and_ext_sense_tb
